// file: design/sdf_pkg.sv
// constants, types and behaviour list for the sigma-delta data filter path
// How it works
// - Changing filter type or oversampling ratio while running yields false data-ready events.
// - Every data-ready event drives each enabled target: interrupt, coprocessor task, DMA trigger.
// - Input mode 2 recovers the modulator clock from a Manchester bitstream.
// - Manchester mode measures the half-bit period over windows of 1024 data transitions.
// - Period measured in one window samples data during the following window only.
// - One glitch on the data input can corrupt the recovered period until recalibration.
package sdf_pkg;

	// ************************************************************
	// widths and counts
	// ************************************************************
	localparam int WORD_W = 32;
	localparam int OSR_W = 8;
	localparam int HALF_W = 16;
	localparam int CAL_W = 10;
	localparam int FIFO_DEPTH = 8;
	localparam logic [CAL_W-1:0] CAL_LAST = 10'h3FF;  // 1024 transitions per window
	localparam logic [HALF_W-1:0] HALF_MAX = 16'hFFFF;
	localparam logic [HALF_W-1:0] HALF_RESET = 16'h0000;
	localparam logic [OSR_W-1:0] OSR_ONE = 8'h01;
	localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
	localparam int MOD_SETTLE_CYCLES = 5;  // modulator clocks the controller adds after the latency

	// ************************************************************
	// modes and filter types
	// ************************************************************
	localparam logic [1:0] MODE_DIRECT = 2'h0;
	localparam logic [1:0] MODE_MANCH = 2'h2;
	localparam logic [1:0] FT_SINC1 = 2'h0;
	localparam logic [1:0] FT_SINC2 = 2'h1;

	typedef logic [WORD_W-1:0] sdf_word_t;

	typedef struct packed {
		logic enable;
		logic [1:0] ftype;
		logic [OSR_W-1:0] osr;
		logic [1:0] mode;
	} sdf_cfg_t;

	typedef struct packed {
		logic cpu_irq;
		logic task_req;
		logic dma_trig;
	} sdf_route_t;

	typedef enum logic [2:0] {
		MS_OFF = 3'b001,
		MS_FIRST = 3'b010,
		MS_RUN = 3'b100
	} sdf_man_state_t;

endpackage

// file: design/sdf_fifo.sv
// word fifo with a registered read port between filter and consumer
`timescale 1ns/1ps
`default_nettype none
module sdf_fifo #(
	parameter int W = 32,
	parameter int D = 8
) (
	// clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
	logic [AW:0] count, next_count;
	logic next_out_valid, push, pop;
	logic [W-1:0] next_out_data;

	// ************************************************************
	// pointer and output stage
	// ************************************************************
	// the output register is refilled whenever it is empty or being taken and a word is stored
	always_comb begin
		push = in_valid_i && in_ready_o;
		pop = (count != '0) && (!out_valid_o || out_ready_i);
		next_wptr = push ? AW'(wptr + 1'b1) : wptr;
		next_rptr = pop ? AW'(rptr + 1'b1) : rptr;
		next_count = (AW+1)'(count + (AW+1)'(push) - (AW+1)'(pop));
		next_out_valid = pop ? 1'b1 : (out_ready_i ? 1'b0 : out_valid_o);
		next_out_data = pop ? mem[rptr] : out_data_o;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
			out_valid_o <= 1'b0;
			out_data_o <= '0;
			in_ready_o <= 1'b0;
		end else if (ce_i) begin
			wptr <= next_wptr;
			rptr <= next_rptr;
			count <= next_count;
			out_valid_o <= next_out_valid;
			out_data_o <= next_out_data;
			in_ready_o <= (next_count < (AW+1)'(D));  // honest full, registered
			if (push) begin
				mem[wptr] <= in_data_i;
			end
		end
	end
endmodule
`default_nettype wire

// file: design/sdf_data_filter.sv
// sigma-delta data filter path: link capture, manchester recovery, sinc filter, events
`timescale 1ns/1ps
`default_nettype none
module sdf_data_filter (
	// clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// modulator link
	input wire logic modulator_clock_input_i,
	input wire logic modulator_data_input_i,
	// configuration, same clock domain
	input wire sdf_pkg::sdf_cfg_t cfg_i,
	input wire sdf_pkg::sdf_route_t route_en_i,
	// filtered data stream
	output sdf_pkg::sdf_word_t data_o,
	output logic data_valid_o,
	input wire logic data_ready_i,
	// events and status
	output sdf_pkg::sdf_route_t event_o,
	output logic overrun_o,
	output logic [sdf_pkg::HALF_W-1:0] cal_half_o
);
	import sdf_pkg::*;

	// ************************************************************
	// link domain capture
	// ************************************************************
	logic lnk_rst_meta, lnk_rst, lnk_tog, next_lnk_tog;
	logic [1:0] lnk_slot, next_lnk_slot;

	// each bit lands in the slot named by the new toggle, so a slot holds still for two link clocks
	always_comb begin
		next_lnk_tog = ~lnk_tog;
		next_lnk_slot = lnk_slot;
		next_lnk_slot[~lnk_tog] = modulator_data_input_i;
		if (lnk_rst) begin
			next_lnk_tog = 1'b0;
			next_lnk_slot = 2'b00;
		end
	end

	always_ff @(posedge modulator_clock_input_i) begin
		lnk_rst_meta <= rst_i;
		lnk_rst <= lnk_rst_meta;
		lnk_tog <= next_lnk_tog;
		lnk_slot <= next_lnk_slot;
	end

	// ************************************************************
	// crossing and pin synchronisers
	// ************************************************************
	logic tog_meta, tog_sync, tog_seen, md_meta, md_sync, md_prev;
	logic dir_strobe, dir_bit, md_edge;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
			tog_seen <= 1'b0;
			md_meta <= 1'b0;
			md_sync <= 1'b0;
			md_prev <= 1'b0;
		end else if (ce_i) begin
			tog_meta <= lnk_tog;
			tog_sync <= tog_meta;
			tog_seen <= tog_sync;
			md_meta <= modulator_data_input_i;
			md_sync <= md_meta;
			md_prev <= md_sync;
		end
	end

	// a toggle edge says a new bit sits stable in its slot
	assign dir_strobe = tog_sync ^ tog_seen;
	assign dir_bit = lnk_slot[tog_sync];
	assign md_edge = md_sync ^ md_prev;

	// ************************************************************
	// manchester clock recovery
	// ************************************************************
	sdf_man_state_t ms, next_ms;
	logic [HALF_W-1:0] gap, next_gap, since_mid, next_since_mid;
	logic [HALF_W-1:0] cal_min, next_cal_min, cal_half, next_cal_half, interval, thresh;
	logic [CAL_W-1:0] cal_cnt, next_cal_cnt;
	logic man_strobe, man_bit, win_end, man_on;

	// a short interval lowers the minimum, so one glitch shrinks the whole next window's period
	always_comb begin
		next_ms = ms;
		next_gap = (gap == HALF_MAX) ? gap : HALF_W'(gap + 1'b1);
		next_since_mid = (since_mid == HALF_MAX) ? since_mid : HALF_W'(since_mid + 1'b1);
		next_cal_min = cal_min;
		next_cal_half = cal_half;
		next_cal_cnt = cal_cnt;
		man_strobe = 1'b0;
		man_bit = md_sync;
		man_on = (cfg_i.mode == MODE_MANCH);
		interval = next_gap;
		thresh = HALF_W'(cal_half + (cal_half >> 1));
		win_end = man_on && md_edge && (cal_cnt == CAL_LAST);
		case (ms)
			MS_OFF: begin
				next_cal_min = HALF_MAX;
				next_cal_cnt = '0;
				next_gap = '0;
				next_since_mid = '0;
				if (man_on) begin
					next_ms = MS_FIRST;
				end
			end
			MS_FIRST, MS_RUN: begin
				if (md_edge) begin
					next_gap = '0;
					next_cal_cnt = CAL_W'(cal_cnt + 1'b1);
					next_cal_min = (interval < cal_min) ? interval : cal_min;
					// only mid-bit edges, at least 3/4 bit after the last, carry data
					if (ms == MS_RUN && since_mid >= thresh) begin
						man_strobe = 1'b1;
						next_since_mid = '0;
					end
					if (win_end) begin
						next_cal_half = next_cal_min;
						next_cal_min = HALF_MAX;
						next_ms = MS_RUN;
					end
				end
				if (!man_on) begin
					next_ms = MS_OFF;
				end
			end
			default: next_ms = MS_OFF;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ms <= MS_OFF;
			gap <= HALF_RESET;
			since_mid <= HALF_RESET;
			cal_min <= HALF_MAX;
			cal_half <= HALF_RESET;
			cal_cnt <= '0;
		end else if (ce_i) begin
			ms <= next_ms;
			gap <= next_gap;
			since_mid <= next_since_mid;
			cal_min <= next_cal_min;
			cal_half <= next_cal_half;
			cal_cnt <= next_cal_cnt;
		end
	end

	// ************************************************************
	// sinc filter and decimation
	// ************************************************************
	logic bit_strobe, bit_val, word_done, pend, next_pend, push_ok, fifo_ready;
	logic ovr, next_ovr;
	logic [WORD_W-1:0] integ [3];
	logic [WORD_W-1:0] next_integ [3];
	logic [WORD_W-1:0] comb_prev [3];
	logic [WORD_W-1:0] next_comb_prev [3];
	logic [WORD_W-1:0] stage, pend_word, next_pend_word;
	logic [OSR_W-1:0] dec_cnt, next_dec_cnt, osr_eff;
	logic [1:0] order;

	// direct mode is the fallback for every mode other than manchester
	assign bit_strobe = man_on ? man_strobe : dir_strobe;
	assign bit_val = man_on ? man_bit : dir_bit;
	assign push_ok = pend && fifo_ready && cfg_i.enable;

	// the decimation compare uses >=, so lowering the ratio mid-word emits a short, false word
	always_comb begin
		order = (cfg_i.ftype == FT_SINC1) ? 2'd1 : ((cfg_i.ftype == FT_SINC2) ? 2'd2 : 2'd3);
		osr_eff = (cfg_i.osr == '0) ? OSR_ONE : cfg_i.osr;
		next_integ = integ;
		next_comb_prev = comb_prev;
		next_dec_cnt = dec_cnt;
		next_pend = push_ok ? 1'b0 : pend;
		next_pend_word = pend_word;
		next_ovr = ovr;
		word_done = 1'b0;
		stage = integ[order - 2'd1];
		if (!cfg_i.enable) begin
			for (int k = 0; k < 3; k++) begin
				next_integ[k] = '0;
				next_comb_prev[k] = '0;
			end
			next_dec_cnt = '0;
			next_pend = 1'b0;
			next_ovr = 1'b0;
		end else if (bit_strobe && pend) begin
			next_ovr = 1'b1;  // a held word stalls the filter; the bit is lost
		end else if (bit_strobe) begin
			next_integ[0] = WORD_W'(integ[0] + WORD_W'(bit_val));
			next_integ[1] = WORD_W'(integ[1] + integ[0]);
			next_integ[2] = WORD_W'(integ[2] + integ[1]);
			next_dec_cnt = OSR_W'(dec_cnt + 1'b1);
			if (next_dec_cnt >= osr_eff) begin
				word_done = 1'b1;
				next_dec_cnt = '0;
				stage = next_integ[order - 2'd1];
				for (int k = 0; k < 3; k++) begin
					if (k < int'(order)) begin
						next_comb_prev[k] = stage;
						stage = WORD_W'(stage - comb_prev[k]);
					end
				end
				next_pend = 1'b1;
				next_pend_word = stage;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			for (int k = 0; k < 3; k++) begin
				integ[k] <= WORD_RESET;
				comb_prev[k] <= WORD_RESET;
			end
			dec_cnt <= '0;
			pend <= 1'b0;
			pend_word <= WORD_RESET;
			ovr <= 1'b0;
		end else if (ce_i) begin
			integ <= next_integ;
			comb_prev <= next_comb_prev;
			dec_cnt <= next_dec_cnt;
			pend <= next_pend;
			pend_word <= next_pend_word;
			ovr <= next_ovr;
		end
	end

	// ************************************************************
	// output buffer
	// ************************************************************
	sdf_fifo #(
		.W(WORD_W),
		.D(FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.in_valid_i(pend && cfg_i.enable),
		.in_ready_o(fifo_ready),
		.in_data_i(pend_word),
		.out_valid_o(data_valid_o),
		.out_ready_i(data_ready_i),
		.out_data_o(data_o)
	);

	// ************************************************************
	// data-ready events and status outputs
	// ************************************************************
	sdf_route_t next_event;

	// one event per word, at the moment it enters the buffer
	always_comb begin
		next_event = push_ok ? route_en_i : '0;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			event_o <= '0;
			overrun_o <= 1'b0;
			cal_half_o <= HALF_RESET;
		end else if (ce_i) begin
			event_o <= next_event;
			overrun_o <= next_ovr;
			cal_half_o <= next_cal_half;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	AST_EVT_ROUTE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && push_ok) |=> (event_o == $past(route_en_i)))
		else $error("event outputs do not follow the routing enables");
	AST_EVT_CAUSE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		($past(ce_i) && event_o != '0) |-> $past(push_ok))
		else $error("event without an accepted word");
	AST_NO_EVT_DIS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && !cfg_i.enable) |=> (event_o == '0 && !pend))
		else $error("event or pending word while disabled");
	AST_WORD_PEND: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && word_done) |=> (pend && dec_cnt == '0))
		else $error("decimated word not held for the buffer");
	AST_CAL_LOAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && win_end && ms != MS_OFF) |=> (ms == MS_RUN && cal_min == HALF_MAX && cal_cnt == '0))
		else $error("calibration window did not close after 1024 transitions");
	AST_HALF_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && !win_end) |=> $stable(cal_half))
		else $error("period changed inside a calibration window");
	AST_DECODE_THR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		man_strobe |-> (ms == MS_RUN && since_mid >= thresh && md_edge))
		else $error("manchester bit taken before three quarters of a bit");
	AST_MODE2: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && cfg_i.mode != MODE_MANCH) |=> (ms == MS_OFF))
		else $error("manchester recovery active outside mode 2");
	AST_GLITCH_MIN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && md_edge && ms != MS_OFF && !win_end && interval < cal_min) |=> (cal_min == $past(interval)))
		else $error("short interval did not lower the measured period");
endmodule
`default_nettype wire

// file: dv/sdf_mod_model.sv
// behavioural modulator model: clocked bitstream or manchester stream
`timescale 1ns/1ps
`default_nettype none
module sdf_mod_model (
	// control from the bench
	input wire logic run_i,
	input wire logic manch_i,
	input wire logic [31:0] pat_i,
	// link to the filter
	output logic mclk_o,
	output logic mdat_o
);
	int idx = 0;

	// ******************************
	// link stimulus
	// ******************************
	initial begin
		mclk_o = 1'b0;
		mdat_o = 1'b0;
	end

	// one loop per bit or half bit; the clock stands still outside a run
	always begin
		if (run_i && !manch_i) begin
			mdat_o = pat_i[idx%32];
			#16 mclk_o = 1'b1;
			#16 mclk_o = 1'b0;
			idx++;
		end else if (run_i) begin
			#53 mdat_o = ~mdat_o;
		end else begin
			#16 mdat_o = ~mdat_o; // idle line toggles so no stale level is read
		end
	end

	// a short noise pulse between two regular edges
	task glitch;
		#15 mdat_o = ~mdat_o;
		#20 mdat_o = ~mdat_o;
	endtask
endmodule
`default_nettype wire

// file: dv/sdf_data_filter_test.sv
// self-checking testbench for the sigma-delta data filter path
`timescale 1ns/1ps
`default_nettype none
module sdf_data_filter_test;
	import sdf_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic mrun = 1'b1;
	logic manch = 1'b0;
	logic [31:0] pat = 32'h0000_0000;
	logic data_ready_i = 1'b1;
	wire mclk;
	wire mdat;
	sdf_cfg_t cfg_i = '0;
	sdf_route_t route_en_i = '0;
	sdf_word_t data_o;
	logic data_valid_o;
	sdf_route_t event_o;
	logic overrun_o;
	logic [HALF_W-1:0] cal_half_o;
	int n_mismatch = 0;
	int check_count = 0;
	int n_ev = 0;
	int n_tk = 0;
	logic [31:0] seed = 32'hf670_aa7d;
	logic found;
	sdf_word_t last_word = '0;

	// ******************************
	// clock, parts and helpers
	// ******************************
	always #5 sys_clk_i = ~sys_clk_i;

	sdf_data_filter i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.modulator_clock_input_i(mclk), .modulator_data_input_i(mdat), .cfg_i(cfg_i),
		.route_en_i(route_en_i), .data_o(data_o), .data_valid_o(data_valid_o),
		.data_ready_i(data_ready_i), .event_o(event_o), .overrun_o(overrun_o), .cal_half_o(cal_half_o));
	sdf_mod_model i_mod (.run_i(mrun), .manch_i(manch), .pat_i(pat), .mclk_o(mclk), .mdat_o(mdat));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// steady word of an all-ones stream: the ratio raised to the filter's order
	function automatic logic [31:0] exp_word(input logic [7:0] r, input logic [1:0] ft);
		logic [31:0] w;
		w = 32'(r);
		if (ft != FT_SINC1)
			w = w * 32'(r);
		if (ft != FT_SINC1 && ft != FT_SINC2)
			w = w * 32'(r);
		return w;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	// disable, write new settings, wait latency plus 5 link clocks, enable
	task automatic settle(input logic [7:0] osr_v, input logic [1:0] ft);
		tick(1);
		cfg_i.enable = 1'b0;
		tick(1);
		seed = lfsr(seed);
		cfg_i.osr = osr_v;
		cfg_i.ftype = ft;
		cfg_i.mode = manch ? MODE_MANCH : MODE_DIRECT;
		// an all-off routing would hide every event, so it is replaced by a fixed corner
		route_en_i = (seed[2:0] == 3'b000) ? 3'b101 : seed[2:0];
		pat = seed;
		n_ev = 0;
		mrun = 1'b1;
		tick(40);
		// a manchester link has no clock pin; two transitions stand for one modulator clock
		if (manch)
			repeat (2 * MOD_SETTLE_CYCLES) @(mdat);
		else
			repeat (MOD_SETTLE_CYCLES) @(posedge mclk);
		tick(1);
		check(n_ev, 0);
		cfg_i.enable = 1'b1;
		n_ev = 0;
		n_tk = 0;
	endtask

	// every event mirrors the enabled targets; taken words are counted
	always @(posedge sys_clk_i) begin
		if (!rst_i && event_o !== 3'b000) begin
			n_ev++;
			check(32'(event_o), 32'(route_en_i));
		end
		if (!rst_i && ce_i && data_valid_o === 1'b1 && data_ready_i) begin
			n_tk++;
			last_word = data_o;
		end
	end

	initial begin
		#1ms;
		n_mismatch++;
		conclude;
	end

	// ******************************
	// main sequence
	// ******************************
	initial begin
		repeat (10) @(posedge sys_clk_i);
		#1 rst_i = 1'b0;
		tick(1);
		check({data_valid_o, event_o, overrun_o}, 0);
		check(cal_half_o, 0);
		// one run per filter type, random ratio: one event per decimated word
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			settle(8'h04 + 8'(seed % 13), 2'(i));
			pat = 32'hFFFF_FFFF;  // known stream so the last word has a closed form
			repeat (8 * int'(cfg_i.osr)) @(posedge mclk);
			mrun = 1'b0;
			tick(40);
			check(n_ev >= 7 && n_ev <= 9, 1);
			check(n_tk, n_ev);
			check(last_word, exp_word(cfg_i.osr, cfg_i.ftype));
		end
		// consumer stalls: buffer fills, bits are lost, then drained
		settle(8'h04, FT_SINC1);
		data_ready_i = 1'b0;
		repeat (80) @(posedge mclk);
		tick(5);
		check({overrun_o, data_valid_o}, 2'b11);
		// frozen by the clock enable: a ready consumer takes nothing
		ce_i = 1'b0;
		data_ready_i = 1'b1;
		tick(4);
		check({overrun_o, data_valid_o}, 2'b11);
		data_ready_i = 1'b0;
		ce_i = 1'b1;
		mrun = 1'b0;
		tick(2);
		data_ready_i = 1'b1;
		tick(40);
		check(n_tk, 10);
		check(n_ev, n_tk);
		cfg_i.enable = 1'b0;
		tick(3);
		check(overrun_o, 0);
		// manchester: half period recovered, glitch takes effect a window later
		manch = 1'b1;
		settle(8'h08, FT_SINC2);
		repeat (2100) @(mdat);
		tick(2);
		check(cal_half_o, 5);
		check(n_ev > 0, 1);
		i_mod.glitch();
		tick(2);
		check(cal_half_o, 5);
		found = 1'b0;
		for (int k = 0; k < 1100 && !found; k++) begin
			@(mdat);
			found = (cal_half_o < 5);
		end
		check(found, 1);
		conclude;
	end
endmodule
`default_nettype wire
